// *** hw/cies_core.sv ***
// execute logic for the instruction subset, with data file and accumulator
`timescale 1ns/1ps
module cies_core (
    // clock, reset and enable
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clk_en_in,
    // program memory
    output logic [12:0]      prog_addr_out,
    input  wire logic [13:0] instr_in,
    // program page latch
    input  wire logic [4:0]  program_page_latch_in,
    // watchdog time base
    input  wire logic        watchdog_tick_in,
    // data file side access
    input  wire logic        file_wr_en_in,
    input  wire logic [6:0]  file_wr_addr_in,
    input  wire logic [7:0]  file_wr_data_in,
    input  wire logic [6:0]  file_rd_addr_in,
    output logic [7:0]       file_rd_data_out,
    // accumulator and status
    output logic [7:0]       acc_out,
    output logic             zero_flag_out,
    output logic             carry_flag_out,
    output logic             half_carry_flag_out,
    output logic             watchdog_expired_flag_out,
    output logic             power_down_flag_out,
    // watchdog state
    output logic [7:0]       watchdog_counter_out,
    output logic [7:0]       watchdog_prescaler_out,
    // pin direction registers five, six and seven
    output logic [7:0]       dir5_out,
    output logic [7:0]       dir6_out,
    output logic [7:0]       dir7_out,
    // execution events
    output logic             retire_out,
    output logic             flush_out,
    output logic             unsupported_out
);

    // ************************************************************************
    // state
    // ************************************************************************
    typedef struct packed {
        cies_pkg::cies_state_t  st;
        logic [12:0]            pc;
        logic                   skip_adv;
        logic [7:0]             acc;
        logic                   z;
        logic                   c;
        logic                   dc;
        logic                   expired;
        logic                   pd;
        logic [7:0]             wdt;
        logic [7:0]             presc;
        logic [2:0][7:0]        dir;
        logic                   retire;
        logic                   flush;
        logic                   unsupported;
        logic [7:0]             rd_data;
        logic [127:0][7:0]      file;
    } cies_core_state_t;

    cies_core_state_t state_reg;
    cies_core_state_t state_next;

    cies_alu_if alu_bus ();

    cies_alu u_alu (
        .alu (alu_bus)
    );

    // ************************************************************************
    // instruction fields
    // ************************************************************************
    logic [6:0]  faddr;
    logic        dest_file;
    logic [7:0]  literal;
    logic [10:0] branch_k;
    logic [2:0]  dir_sel;
    logic [7:0]  fval;
    logic        is_file_op;
    logic        is_inv;
    logic        is_dec;
    logic        is_decskip;
    logic        is_inc;
    logic        is_subf;
    logic        is_swap;

    assign faddr     = instr_in[cies_pkg::FADDR_W-1:0];
    assign dest_file = instr_in[cies_pkg::DEST_BIT];
    assign literal   = instr_in[cies_pkg::K8_HI:0];
    assign branch_k  = instr_in[cies_pkg::K11_HI:0];
    assign dir_sel   = instr_in[cies_pkg::DIRSEL_HI:0];
    assign fval      = state_reg.file[faddr];

    assign is_inv     = cies_pkg::cies_match(instr_in, cies_pkg::OPC_INVF,
                                             cies_pkg::MASK_FILE);
    assign is_dec     = cies_pkg::cies_match(instr_in, cies_pkg::OPC_FILE_MINUS_ONE_OP,
                                             cies_pkg::MASK_FILE);
    assign is_decskip = cies_pkg::cies_match(instr_in, cies_pkg::OPC_DECSKIP,
                                             cies_pkg::MASK_FILE);
    assign is_inc     = cies_pkg::cies_match(instr_in, cies_pkg::OPC_FILE_PLUS_ONE_OP,
                                             cies_pkg::MASK_FILE);
    assign is_subf    = cies_pkg::cies_match(instr_in, cies_pkg::OPC_SUBF,
                                             cies_pkg::MASK_FILE);
    assign is_swap    = cies_pkg::cies_match(instr_in, cies_pkg::OPC_NIBBLE_EXCHANGE_OP,
                                             cies_pkg::MASK_FILE);
    assign is_file_op = is_inv | is_dec | is_decskip | is_inc | is_subf
                      | is_swap;

    // ************************************************************************
    // arithmetic unit operands
    // ************************************************************************
    always_comb
    begin
        alu_bus.a  = fval;
        alu_bus.b  = state_reg.acc;
        alu_bus.op = cies_pkg::ALU_PASS;
        if (cies_pkg::cies_match(instr_in, cies_pkg::OPC_SUBLIT,
                                 cies_pkg::MASK_LIT))
        begin
            alu_bus.a  = literal;
            alu_bus.op = cies_pkg::ALU_SUB;
        end
        else if (is_inv)
            alu_bus.op = cies_pkg::ALU_INV;
        else if (is_dec || is_decskip)
            alu_bus.op = cies_pkg::ALU_DEC;
        else if (is_inc)
            alu_bus.op = cies_pkg::ALU_INC;
        else if (is_subf)
            alu_bus.op = cies_pkg::ALU_SUB;
        else if (is_swap)
            alu_bus.op = cies_pkg::ALU_SWAP;
    end

    // ************************************************************************
    // next state
    // ************************************************************************
    always_comb
    begin
        state_next             = state_reg;
        state_next.retire      = 1'b0;
        state_next.flush       = 1'b0;
        state_next.unsupported = 1'b0;
        state_next.rd_data     = state_reg.file[file_rd_addr_in];

        // side port write; a core write to the same location below wins
        if (file_wr_en_in)
            state_next.file[file_wr_addr_in] = file_wr_data_in;

        // free-running time base; the counter just wraps, nothing acts on its overflow
        if (watchdog_tick_in)
        begin
            state_next.presc = state_reg.presc + 8'h01;
            if (&state_reg.presc)
                state_next.wdt = state_reg.wdt + 8'h01;
        end

        case (state_reg.st)
            cies_pkg::ST_RUN:
            begin
                state_next.retire = 1'b1;
                state_next.pc     = cies_pkg::PC_W'(state_reg.pc + 1'b1);
                if (cies_pkg::cies_match(instr_in, cies_pkg::OPC_ZACC,
                                         cies_pkg::MASK_ALL))
                begin
                    state_next.acc = cies_pkg::BYTE_ZERO;
                    state_next.z   = 1'b1;
                end
                else if (cies_pkg::cies_match(instr_in, cies_pkg::OPC_WDKICK,
                                              cies_pkg::MASK_ALL))
                begin
                    // a kick in the same cycle as a tick wins over the tick
                    state_next.wdt     = cies_pkg::BYTE_ZERO;
                    state_next.presc   = cies_pkg::BYTE_ZERO;
                    state_next.expired = 1'b1;
                    state_next.pd      = 1'b1;
                end
                else if (cies_pkg::cies_match(instr_in, cies_pkg::OPC_DIRLOAD,
                                              cies_pkg::MASK_DIR))
                begin
                    // selector values below five are not direction registers
                    if (dir_sel >= cies_pkg::DIR_FIRST &&
                        dir_sel <= cies_pkg::DIR_LAST)
                        state_next.dir[2'(dir_sel - cies_pkg::DIR_FIRST)] =
                            state_reg.acc;
                    else
                        state_next.unsupported = 1'b1;
                end
                else if (cies_pkg::cies_match(instr_in, cies_pkg::OPC_BRANCH,
                                              cies_pkg::MASK_BRANCH))
                begin
                    state_next.pc = {program_page_latch_in[cies_pkg::PAGE_HI:
                                                           cies_pkg::PAGE_LO],
                                     branch_k};
                    state_next.skip_adv = 1'b0;
                    state_next.st       = cies_pkg::ST_FLUSH;
                end
                else if (cies_pkg::cies_match(instr_in, cies_pkg::OPC_SUBLIT,
                                              cies_pkg::MASK_LIT))
                begin
                    state_next.acc = alu_bus.result;
                    state_next.c   = alu_bus.carry;
                    state_next.dc  = alu_bus.half_carry;
                    state_next.z   = alu_bus.zero;
                end
                else if (is_file_op)
                begin
                    if (dest_file)
                        state_next.file[faddr] = alu_bus.result;
                    else
                        state_next.acc = alu_bus.result;
                    // swap and count-down-skip leave every flag alone
                    if (is_inv || is_dec || is_inc || is_subf)
                        state_next.z = alu_bus.zero;
                    if (is_subf)
                    begin
                        state_next.c  = alu_bus.carry;
                        state_next.dc = alu_bus.half_carry;
                    end
                    if (is_decskip && alu_bus.zero)
                    begin
                        state_next.skip_adv = 1'b1;
                        state_next.st       = cies_pkg::ST_FLUSH;
                    end
                end
                else
                    state_next.unsupported = 1'b1;
            end
            cies_pkg::ST_FLUSH:
            begin
                // the word on instr_in is discarded; a no-op runs instead
                state_next.flush = 1'b1;
                if (state_reg.skip_adv)
                    state_next.pc = cies_pkg::PC_W'(state_reg.pc + 1'b1);
                state_next.skip_adv = 1'b0;
                state_next.st       = cies_pkg::ST_RUN;
            end
            default:
            begin
                state_next.st = cies_pkg::ST_RUN;
            end
        endcase
    end

    // ************************************************************************
    // registers
    // ************************************************************************
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_reg             <= '0;
            state_reg.st          <= cies_pkg::ST_RUN;
            state_reg.pc          <= cies_pkg::PC_RST;
            state_reg.acc         <= cies_pkg::ACC_RST;
            state_reg.expired     <= cies_pkg::EXP_RST;
            state_reg.pd          <= cies_pkg::PD_RST;
            state_reg.dir         <= {3{cies_pkg::DIR_RST}};
        end
        else if (clk_en_in)
        begin
            state_reg <= state_next;
        end
    end

    // ************************************************************************
    // outputs
    // ************************************************************************
    assign prog_addr_out             = state_reg.pc;
    assign file_rd_data_out          = state_reg.rd_data;
    assign acc_out                   = state_reg.acc;
    assign zero_flag_out             = state_reg.z;
    assign carry_flag_out            = state_reg.c;
    assign half_carry_flag_out       = state_reg.dc;
    assign watchdog_expired_flag_out = state_reg.expired;
    assign power_down_flag_out       = state_reg.pd;
    assign watchdog_counter_out      = state_reg.wdt;
    assign watchdog_prescaler_out    = state_reg.presc;
    assign dir5_out                  = state_reg.dir[0];
    assign dir6_out                  = state_reg.dir[1];
    assign dir7_out                  = state_reg.dir[2];
    assign retire_out                = state_reg.retire;
    assign flush_out                 = state_reg.flush;
    assign unsupported_out           = state_reg.unsupported;

endmodule : cies_core

// *** hw/cies_pkg.sv ***
// constants, types and helpers shared by the instruction execute subset core
// ****************************************************************************
// What this block does
// - zero-accumulator op clears accumulator, sets zero flag, one cycle
// - invert-file op writes inverted file to destination, updates zero
// - destination bit 0 writes accumulator, bit 1 writes back to file
// - watchdog-kick op clears watchdog counter and its prescaler
// - watchdog-kick op sets expired and power-down flags, others unchanged
// - file-minus-one op decrements file into destination, updates zero
// - count-down-skip op decrements file into destination, flags untouched
// - count-down-skip zero result discards next word, runs no-op instead
// - branch loads eleven-bit field into low pc, two cycles, no flags
// - branch copies page latch bits four, three into pc twelve, eleven
// - file-plus-one op increments with wrap into destination, sets zero
// - literal-minus-acc result goes to accumulator; sets c, dc, z
// - file-minus-acc result goes to destination; sets c, dc, z
// - subtract carry is inverted borrow: one when result not negative
// - nibble-exchange op swaps file nibbles into destination, no flags
// - direction-load copies acc to direction reg; selectors 5 to 7 only
// ****************************************************************************
package cies_pkg;

    // ************************************************************************
    // widths and field positions
    // ************************************************************************
    localparam int PC_W       = 13;
    localparam int INSTR_W    = 14;
    localparam int DATA_W     = 8;
    localparam int FADDR_W    = 7;
    localparam int FILE_DEPTH = 128;
    localparam int PAGE_W     = 5;
    localparam int WDT_W      = 8;
    localparam int PRESC_W    = 8;
    localparam int K11_W      = 11;
    localparam int NIB_W      = 4;
    localparam int DEST_BIT   = 7;
    localparam int K8_HI      = 7;
    localparam int K11_HI     = 10;
    localparam int PAGE_HI    = 4;
    localparam int PAGE_LO    = 3;
    localparam int DIRSEL_HI  = 2;

    // ************************************************************************
    // opcode values and masks
    // ************************************************************************
    localparam logic [13:0] MASK_ALL    = 14'h3fff;
    localparam logic [13:0] MASK_FILE   = 14'h3f00;
    localparam logic [13:0] MASK_BRANCH = 14'h3800;
    localparam logic [13:0] MASK_LIT    = 14'h3e00;
    localparam logic [13:0] MASK_DIR    = 14'h3ff8;
    localparam logic [13:0] OPC_ZACC    = 14'h0103;
    localparam logic [13:0] OPC_WDKICK  = 14'h0064;
    localparam logic [13:0] OPC_DIRLOAD = 14'h0060;
    localparam logic [13:0] OPC_INVF    = 14'h0900;
    localparam logic [13:0] OPC_FILE_MINUS_ONE_OP    = 14'h0300;
    localparam logic [13:0] OPC_DECSKIP = 14'h0b00;
    localparam logic [13:0] OPC_FILE_PLUS_ONE_OP    = 14'h0a00;
    localparam logic [13:0] OPC_SUBF    = 14'h0200;
    localparam logic [13:0] OPC_NIBBLE_EXCHANGE_OP   = 14'h0e00;
    localparam logic [13:0] OPC_BRANCH  = 14'h2800;
    localparam logic [13:0] OPC_SUBLIT  = 14'h3c00;
    localparam logic [2:0]  DIR_FIRST   = 3'h5;
    localparam logic [2:0]  DIR_LAST    = 3'h7;

    // ************************************************************************
    // reset values
    // ************************************************************************
    localparam logic [12:0] PC_RST   = 13'h0000;
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [7:0]  DIR_RST  = 8'hff;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic        EXP_RST  = 1'b1;
    localparam logic        PD_RST   = 1'b1;

    // ************************************************************************
    // types
    // ************************************************************************
    typedef enum logic [2:0] {
        ALU_PASS = 3'h0,
        ALU_INV  = 3'h1,
        ALU_DEC  = 3'h2,
        ALU_INC  = 3'h3,
        ALU_SUB  = 3'h4,
        ALU_SWAP = 3'h5
    } cies_alu_op_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_FLUSH = 2'b10
    } cies_state_t;

    // ************************************************************************
    // helpers
    // ************************************************************************
    function automatic logic cies_match(input logic [13:0] instr,
                                        input logic [13:0] val,
                                        input logic [13:0] mask);
        return (instr & mask) == val;
    endfunction : cies_match

    function automatic logic cies_is_zero(input logic [7:0] v);
        return v == BYTE_ZERO;
    endfunction : cies_is_zero

endpackage : cies_pkg

// *** hw/cies_alu_if.sv ***
// carrier between the core sequencer and its arithmetic unit
`timescale 1ns/1ps
interface cies_alu_if;
    cies_pkg::cies_alu_op_t op;
    logic [7:0]             a;
    logic [7:0]             b;
    logic [7:0]             result;
    logic                   zero;
    logic                   carry;
    logic                   half_carry;

    modport core (output op, output a, output b,
                  input result, input zero, input carry, input half_carry);
    modport alu  (input op, input a, input b,
                  output result, output zero, output carry,
                  output half_carry);
endinterface : cies_alu_if

// *** hw/cies_alu.sv ***
// combinational arithmetic unit of the execute subset core
`timescale 1ns/1ps
module cies_alu (
    // operands and results
    cies_alu_if.alu alu
);
    localparam logic [8:0] ONE9 = 9'h001;
    localparam logic [4:0] ONE5 = 5'h01;

    logic [8:0] diff;
    logic [4:0] low_diff;

    // a minus b as a plus inverted b plus one, so carry out is not-borrow
    assign diff     = {1'b0, alu.a} + {1'b0, ~alu.b} + ONE9;
    assign low_diff = {1'b0, alu.a[cies_pkg::NIB_W-1:0]}
                    + {1'b0, ~alu.b[cies_pkg::NIB_W-1:0]} + ONE5;

    always_comb
    begin
        alu.carry      = 1'b0;
        alu.half_carry = 1'b0;
        case (alu.op)
            cies_pkg::ALU_INV:  alu.result = ~alu.a;
            cies_pkg::ALU_DEC:  alu.result = alu.a - 8'h01;
            cies_pkg::ALU_INC:  alu.result = alu.a + 8'h01;
            cies_pkg::ALU_SWAP:
                alu.result = {alu.a[cies_pkg::NIB_W-1:0],
                              alu.a[cies_pkg::DATA_W-1:cies_pkg::NIB_W]};
            cies_pkg::ALU_SUB:
            begin
                alu.result     = diff[cies_pkg::DATA_W-1:0];
                alu.carry      = diff[cies_pkg::DATA_W];
                alu.half_carry = low_diff[cies_pkg::NIB_W];
            end
            default:            alu.result = alu.a;
        endcase
        alu.zero = cies_pkg::cies_is_zero(alu.result);
    end
endmodule : cies_alu

// *** verification/cies_prog_rom.sv ***
// program memory model answering the core's fetch address
`timescale 1ns/1ps
module cies_prog_rom (
    // fetch port
    input  wire logic [12:0] addr_in,
    output logic [13:0]      data_out
);
    logic [13:0] mem [0:8191];
    // words never loaded read as zero, which lies outside the subset
    initial foreach (mem[i]) mem[i] = 14'h0000;
    assign data_out = mem[addr_in];
endmodule : cies_prog_rom

// *** verification/cies_core_assertions.sv ***
// concurrent checks on the execute subset core, bound to its ports
`timescale 1ns/1ps
module cies_core_assertions (
    // clock, reset and fetch
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic        clk_en_in,
    input wire logic [12:0] prog_addr_out,
    input wire logic [13:0] instr_in,
    input wire logic [4:0]  program_page_latch_in,
    // architectural state
    input wire logic [7:0]  acc_out,
    input wire logic        zero_flag_out,
    input wire logic        carry_flag_out,
    input wire logic        watchdog_expired_flag_out,
    input wire logic        power_down_flag_out,
    input wire logic [7:0]  watchdog_counter_out,
    input wire logic [7:0]  watchdog_prescaler_out,
    input wire logic [7:0]  dir5_out,
    // execution events
    input wire logic        retire_out,
    input wire logic        flush_out
);
    // ******
    // properties
    // ******
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    logic [12:0] tgt_c;
    logic [8:0]  sub_c;
    logic [1:0]  zc_c;
    // nine bits so the top bit carries the borrow out
    assign sub_c = {1'b0, instr_in[7:0]} - {1'b0, acc_out};
    assign tgt_c = {program_page_latch_in[4:3], instr_in[10:0]};
    assign zc_c  = {zero_flag_out, carry_flag_out};
    // retire after the edge tells an executed slot from a discarded one
    sequence s_exec(logic [13:0] v, logic [13:0] m);
        clk_en_in && cies_pkg::cies_match(instr_in, v, m) ##1 retire_out;
    endsequence
    a_zacc_clears: assert property (s_exec(cies_pkg::OPC_ZACC,
        cies_pkg::MASK_ALL) |-> acc_out == 8'h00 && zero_flag_out)
        else $error("accumulator clear wrong");
    a_kick_clears: assert property (s_exec(cies_pkg::OPC_WDKICK,
        cies_pkg::MASK_ALL) |-> watchdog_counter_out == 8'h00
        && watchdog_prescaler_out == 8'h00)
        else $error("watchdog not cleared");
    a_kick_flags: assert property (s_exec(cies_pkg::OPC_WDKICK,
        cies_pkg::MASK_ALL) |-> watchdog_expired_flag_out
        && power_down_flag_out && $stable(zc_c))
        else $error("kick status wrong");
    a_skip_flags: assert property (s_exec(cies_pkg::OPC_DECSKIP,
        cies_pkg::MASK_FILE) |-> $stable(zc_c))
        else $error("skip changed flags");
    a_skip_flush: assert property (s_exec(cies_pkg::OPC_DECSKIP,
        14'h3f80) ##0 acc_out == 8'h00 && clk_en_in |=> flush_out)
        else $error("zero skip not discarded");
    a_swap_flags: assert property (s_exec(cies_pkg::OPC_NIBBLE_EXCHANGE_OP,
        cies_pkg::MASK_FILE) |-> $stable(zc_c))
        else $error("swap changed flags");
    a_branch_target: assert property (
        s_exec(cies_pkg::OPC_BRANCH, cies_pkg::MASK_BRANCH)
        |-> prog_addr_out == $past(tgt_c) && $stable(zc_c))
        else $error("branch target wrong");
    a_branch_flush: assert property (s_exec(cies_pkg::OPC_BRANCH,
        cies_pkg::MASK_BRANCH) ##0 clk_en_in
        |=> flush_out && $stable(prog_addr_out))
        else $error("branch not two cycles");
    a_lit_sub: assert property (
        s_exec(cies_pkg::OPC_SUBLIT, cies_pkg::MASK_LIT)
        |-> {!carry_flag_out, acc_out} == $past(sub_c)
        && zero_flag_out == (acc_out == 8'h00))
        else $error("literal subtract wrong");
    a_dir_load: assert property (s_exec(14'h0065,
        cies_pkg::MASK_ALL) |-> dir5_out == $past(acc_out))
        else $error("direction load wrong");
endmodule : cies_core_assertions
bind cies_core cies_core_assertions i_chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .prog_addr_out(prog_addr_out), .instr_in(instr_in),
    .program_page_latch_in(program_page_latch_in), .acc_out(acc_out),
    .zero_flag_out(zero_flag_out), .carry_flag_out(carry_flag_out),
    .watchdog_expired_flag_out(watchdog_expired_flag_out),
    .power_down_flag_out(power_down_flag_out),
    .watchdog_counter_out(watchdog_counter_out),
    .watchdog_prescaler_out(watchdog_prescaler_out),
    .dir5_out(dir5_out), .retire_out(retire_out), .flush_out(flush_out)
);

// *** verification/cies_core_tb_top.sv ***
// self-checking bench running a short program through the core
`timescale 1ns/1ps
module cies_core_tb_top;
    typedef struct packed {logic [7:0] a; logic z; logic c; logic d;}
        cies_exp_t;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b0;
    logic        tick = 1'b0, wr_en = 1'b0;
    logic [6:0]  wr_addr = 7'h00, rd_addr = 7'h00;
    logic [7:0]  wr_data = 8'h00, rd_data, acc, wdt, presc, dir5, dir6, dir7, r;
    logic [4:0]  latch = 5'h18;
    logic [12:0] pc;
    logic [13:0] instr;
    logic        z, c, dc, expd, pd, retire, flush, unsup;
    logic [7:0]  pre [4];
    cies_exp_t   q[$];
    cies_exp_t   e;
    int          fail_count = 0, n_tests = 0, n_flush = 0, n_unsup = 0, pa = 0;
    cies_prog_rom i_rom (.addr_in(pc), .data_out(instr));
    cies_core i_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
        .prog_addr_out(pc), .instr_in(instr),
        .program_page_latch_in(latch), .watchdog_tick_in(tick),
        .file_wr_en_in(wr_en), .file_wr_addr_in(wr_addr),
        .file_wr_data_in(wr_data), .file_rd_addr_in(rd_addr),
        .file_rd_data_out(rd_data), .acc_out(acc), .zero_flag_out(z),
        .carry_flag_out(c), .half_carry_flag_out(dc),
        .watchdog_expired_flag_out(expd), .power_down_flag_out(pd),
        .watchdog_counter_out(wdt), .watchdog_prescaler_out(presc),
        .dir5_out(dir5), .dir6_out(dir6), .dir7_out(dir7), .retire_out(retire),
        .flush_out(flush), .unsupported_out(unsup)
    );
    // ******
    // tasks
    // ******
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (!ok)
        begin
            fail_count++;
            $display("ERROR at %0t: %s", $time, m);
        end
    endtask : chk
    // program word plus the state expected once it retires
    task automatic op(input logic [13:0] w, input cies_exp_t x);
        i_rom.mem[pa] = w;
        q.push_back(x);
        pa++;
    endtask : op
    task automatic rd(input logic [6:0] a, input logic [7:0] x);
        @(negedge clk_in) rd_addr = a;
        repeat (2) @(negedge clk_in);
        chk(rd_data === x, "file content wrong");
    endtask : rd
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial forever #4 clk_in = ~clk_in;
    always @(negedge clk_in) tick <= 1'($urandom());
    // scoreboard: oldest note against each retired instruction
    always @(negedge clk_in)
    begin
        if (flush === 1'b1) n_flush++;
        if (unsup === 1'b1 && q.size() > 0) n_unsup++;
        if (retire === 1'b1 && q.size() > 0)
        begin
            e = q.pop_front();
            chk({acc, z, c, dc} === e, "accumulator or flags wrong");
        end
    end
    initial
    begin
        void'($urandom(88364));
        // load the image only after the memory model has zeroed itself
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        r = 8'($urandom());
        latch = {2'b11, 3'($urandom())};
        pre = '{8'h01, 8'hff, r, 8'h03};
        // four clears cover the cycles spent preloading the file
        repeat (4) op(14'h0103, {8'h00, 3'b100});
        op(14'h3c02, {8'h02, 3'b011});
        op(14'h0213, {8'h01, 3'b011});
        op(14'h3c00, {8'hff, 3'b000});
        op(14'h0912, {~r, r == 8'hff, 2'b00});
        op(14'h0a11, {8'h00, 3'b100});
        op(14'h0e12, {r[3:0], r[7:4], 3'b100});
        op(14'h0313, {8'h02, 3'b000});
        op(14'h0065, {8'h02, 3'b000});
        op(14'h0066, {8'h02, 3'b000});
        op(14'h0061, {8'h02, 3'b000});
        op(14'h0103, {8'h00, 3'b100});
        op(14'h0064, {8'h00, 3'b100});
        op(14'h3c05, {8'h05, 3'b011});
        op(14'h0b10, {8'h00, 3'b011});
        i_rom.mem[pa] = 14'h3c55;
        pa++;
        op(14'h0b13, {8'h02, 3'b011});
        op(14'h2820, {8'h02, 3'b011});
        i_rom.mem[pa] = 14'h3c77;
        pa = 13'h1820;
        op(14'h0292, {8'h02, r == 8'h02, r >= 8'h02,
            r[3:0] >= 4'h2});
        sys_rst_in = 1'b0;
        clk_en_in = 1'b1;
        wr_en = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wr_addr = 7'(16 + i);
            wr_data = pre[i];
            @(negedge clk_in);
        end
        wr_en = 1'b0;
        for (int k = 0; k < 100 && q.size() > 0; k++) @(negedge clk_in);
        chk(q.size() == 0, "program did not complete");
        rd(7'h10, 8'h01);
        rd(7'h11, 8'hff);
        rd(7'h12, 8'(r - 8'h02));
        rd(7'h13, 8'h03);
        chk(dir5 === 8'h02 && dir6 === 8'h02, "direction wrong");
        chk(dir7 === 8'hff && n_unsup == 1, "bad selector acted");
        chk(n_flush == 2, "discard count wrong");
        chk(expd === 1'b1 && pd === 1'b1, "status wrong");
        final_report();
    end
endmodule : cies_core_tb_top
